// ---- shared/cmc_pkg.sv ----
// Purpose: constants and types for the transceiver mode control block
// Assumes: 25 MHz clk, asynchronous active-low reset
// Notes: Summary of operation
// Summary of operation
// - after power-up the transceiver sits in Off mode until software picks another mode.
// - Off mode can be chosen in any chip mode except Fail-safe, which forces Wake Capable, and stops all bus activity.
// - in Off mode bus wake activity is ignored and never raises a wake event.
// - Normal mode is entered only by a software command while the chip is in Normal mode.
// - after Normal mode is enabled no dominant level is driven before the enabling time ends.
// - a low transmit input during enabling is suppressed until it returns high after the time.
// - in Normal mode a low transmit input gives a dominant bus and a high one recessive.
// - the bus state is shown on the receive output while reception is active.
// - in Wake Capable mode a wake pattern on the bus raises a wake event; later patterns are ignored until the detector is rearmed.
// - a Receive-only mode exists as a separate software-selectable mode.
// - the data path supports data-phase rates up to 2 Mbaud.
// - in Receive-only mode the driver is off while reception keeps working.
// - the mode field codes Wake Capable as 01 and keeps that value after a bus wake.
// - after a bus wake the receive output is held low until software writes a mode or the chip enters Stop, Sleep or Fail-safe.
package cmc_pkg;
    localparam logic [1:0] CMC_MODE_OFF = 2'h0;
    localparam logic [1:0] CMC_MODE_WAKE = 2'h1;
    localparam logic [1:0] CMC_MODE_RXONLY = 2'h2;
    localparam logic [1:0] CMC_MODE_NORMAL = 2'h3;
    localparam logic [1:0] CMC_MODE_RESET = 2'h0;
    localparam logic [2:0] CMC_CHIP_NORMAL = 3'h0;
    localparam logic [2:0] CMC_CHIP_STOP = 3'h1;
    localparam logic [2:0] CMC_CHIP_SLEEP = 3'h2;
    localparam logic [2:0] CMC_CHIP_RESTART = 3'h3;
    localparam logic [2:0] CMC_CHIP_FAILSAFE = 3'h4;
    localparam int CMC_CLK_MHZ = 25;
    localparam int CMC_EN_TIME_NS = 8000;
    localparam int CMC_EN_CYC = (CMC_EN_TIME_NS * CMC_CLK_MHZ + 999) / 1000;
    localparam int CMC_WAKE1_NS = 500;
    localparam int CMC_WAKE2_NS = 1800000;
    localparam int CMC_WAKE1_CYC = (CMC_WAKE1_NS * CMC_CLK_MHZ + 999) / 1000;
    localparam int CMC_WAKE2_CYC = (CMC_WAKE2_NS * CMC_CLK_MHZ) / 1000;
    localparam int CMC_MAX_BAUD = 2000000;
    localparam int CMC_CNT_W = 16;
    typedef struct packed {
        logic valid;
        logic [1:0] mode;
    } cmc_cmd_s;
    typedef enum logic [3:0] {
        CMC_W_IDLE = 4'h1,
        CMC_W_DOM1 = 4'h2,
        CMC_W_REC = 4'h4,
        CMC_W_DOM2 = 4'h8
    } cmc_wst_e;
endpackage : cmc_pkg

// ---- sim/cmc_ctrl_model.sv ----
// Purpose: protocol controller model driving transmit data
// Assumes: one bit lasts BIT_CYC clk cycles, 520 ns, inside the 2 Mbaud limit
// Notes: hold_low breaks the enabling wait on purpose
`timescale 1ns/1ps
`default_nettype none
module cmc_ctrl_model #(
    parameter int BIT_CYC = 13
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic go,
    input wire logic hold_low,
    output var logic tx_data_in
);
    int cnt;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= 0;
        end else if (go) begin
            cnt <= BIT_CYC;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    // recessive unless a bit or a commanded fault is under way
    assign tx_data_in = !(hold_low || cnt > 0);
endmodule : cmc_ctrl_model
`default_nettype wire

// ---- sim/cmc_top_tb_top.sv ----
// Purpose: self-checking bench for transceiver mode control
// Assumes: EN_CYC 20, WAKE1 4, WAKE2 40 shorten the long counts
// Notes: bus line is our driver ORed with a remote node
`timescale 1ns/1ps
`default_nettype none
module cmc_top_tb_top;
    import cmc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    cmc_cmd_s mode_cmd = '0;
    logic [2:0] chip_mode = CMC_CHIP_NORMAL;
    logic go = 1'b0;
    logic hold_low = 1'b0;
    logic remote_dom = 1'b0;
    wire logic tx_data_in;
    wire logic bus_rx_dom;
    logic [1:0] mode_out;
    logic bus_drive_dom, drv_enable, rx_data_out, wake_event;
    int num_errors = 0;
    int compares = 0;
    int w;
    assign bus_rx_dom = bus_drive_dom | remote_dom;
    always #20 clk = ~clk;
    cmc_top #(.EN_CYC(20), .WAKE1_CYC(4), .WAKE2_CYC(40)) i_dut (.clk(clk), .resetn(resetn),
        .mode_cmd(mode_cmd), .chip_mode(chip_mode), .tx_data_in(tx_data_in),
        .bus_rx_dom(bus_rx_dom), .mode_out(mode_out), .bus_drive_dom(bus_drive_dom),
        .drv_enable(drv_enable), .rx_data_out(rx_data_out), .wake_event(wake_event));
    cmc_ctrl_model i_ctrl (.clk(clk), .resetn(resetn), .go(go), .hold_low(hold_low),
        .tx_data_in(tx_data_in));
    task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic cmd(input logic [1:0] m);
        mode_cmd <= '{valid: 1'b1, mode: m};
        @(posedge clk);
        mode_cmd <= '0;
        #1;
    endtask : cmd
    task automatic pulse_bit;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1;
    endtask : pulse_bit
    // counts driven cycles; an X on the driver turns the two-state int count to 0, so a zero check still matches
    task automatic count_drv(input int n, output int d);
        d = 0;
        repeat (n) begin
            cyc(1);
            d += bus_drive_dom;
        end
    endtask : count_drv
    // dominant, recessive, dominant of 10 cycles each, all inside [WAKE1, WAKE2)
    task automatic pattern(output int n);
        n = 0;
        for (int i = 0; i < 60; i++) begin
            remote_dom <= (i < 10) || (i >= 20 && i < 30);
            cyc(1);
            n += wake_event;
        end
    endtask : pattern
    task automatic t_off;
        chk(mode_out, CMC_MODE_OFF);
        chk(rx_data_out, 1'b1);
        pattern(w);
        chk(w[1:0], 2'h0);
    endtask : t_off
    task automatic t_modes;
        chip_mode <= CMC_CHIP_STOP;
        cyc(1);
        cmd(CMC_MODE_NORMAL);
        chk(mode_out, CMC_MODE_OFF);
        cmd(CMC_MODE_RXONLY);
        chk(mode_out, CMC_MODE_RXONLY);
        remote_dom <= 1'b1;
        cyc(4);
        chk(rx_data_out, 1'b0);
        chk(drv_enable, 1'b0);
        remote_dom <= 1'b0;
        cyc(4);
        chk(rx_data_out, 1'b1);
        cmd(CMC_MODE_OFF);
        chk(mode_out, CMC_MODE_OFF);
        chip_mode <= CMC_CHIP_NORMAL;
        cyc(2);
    endtask : t_modes
    task automatic t_enable;
        int d;
        cmd(CMC_MODE_NORMAL);
        chk(mode_out, CMC_MODE_NORMAL);
        chk(drv_enable, 1'b1);
        hold_low <= 1'b1;
        count_drv(45, d);
        chk(d[1:0], 2'h0);
        hold_low <= 1'b0;
        cyc(5);
        pulse_bit();
        count_drv(25, d);
        chk(d[7:6], 2'h0);
        chk(d[5:4], 2'h0);
        chk(d[3:2], 2'h3);
        chk(d[1:0], 2'h1);
        hold_low <= 1'b1;
        cyc(6);
        chk(bus_drive_dom, 1'b1);
        chk(rx_data_out, 1'b0);
        cmd(CMC_MODE_OFF);
        chk(bus_drive_dom, 1'b0);
        chk(drv_enable, 1'b0);
        hold_low <= 1'b0;
        cyc(4);
        cmd(CMC_MODE_NORMAL);
        cyc(3);
        pulse_bit();
        count_drv(30, d);
        chk(d[1:0], 2'h0);
        cmd(CMC_MODE_OFF);
    endtask : t_enable
    task automatic t_wake;
        cmd(CMC_MODE_NORMAL);
        chip_mode <= CMC_CHIP_STOP;
        cyc(2);
        chk(mode_out, CMC_MODE_OFF);
        chk(drv_enable, 1'b0);
        chip_mode <= CMC_CHIP_NORMAL;
        cyc(1);
        cmd(CMC_MODE_WAKE);
        chk(mode_out, 2'b01);
        pattern(w);
        chk(w[1:0], 2'h1);
        chk(mode_out, 2'b01);
        chk(rx_data_out, 1'b0);
        pattern(w);
        chk(w[1:0], 2'h0);
        chk(rx_data_out, 1'b0);
        chip_mode <= CMC_CHIP_FAILSAFE;
        cyc(2);
        chk(mode_out, 2'b01);
        pattern(w);
        chk(w[1:0], 2'h1);
        chip_mode <= CMC_CHIP_NORMAL;
        cyc(1);
        cmd(CMC_MODE_OFF);
        cyc(4);
        chk(rx_data_out, 1'b1);
    endtask : t_wake
    task automatic final_report;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report
    initial begin
        #400000;
        num_errors++;
        final_report();
    end
    initial begin
        cyc(5);
        resetn <= 1'b1;
        cyc(1);
        t_off();
        t_modes();
        t_enable();
        t_wake();
        final_report();
    end
endmodule : cmc_top_tb_top
`default_nettype wire

// ---- verilog/cmc_top.sv ----
// Purpose: transceiver mode control and digital pin behaviour
// Assumes: mode command from the serial interface arrives on clk as a one-cycle strobe
// Notes: tx_data_in and bus_rx_dom are pins and are synchronised
`timescale 1ns/1ps
`default_nettype none
module cmc_top #(
    parameter int EN_CYC = cmc_pkg::CMC_EN_CYC,
    parameter int WAKE1_CYC = cmc_pkg::CMC_WAKE1_CYC,
    parameter int WAKE2_CYC = cmc_pkg::CMC_WAKE2_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire cmc_pkg::cmc_cmd_s mode_cmd,
    input wire logic [2:0] chip_mode,
    input wire logic tx_data_in,
    input wire logic bus_rx_dom,
    output logic [1:0] mode_out,
    output logic bus_drive_dom,
    output logic drv_enable,
    output logic rx_data_out,
    output logic wake_event
);
    import cmc_pkg::*;
    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] tx_sync;
        logic [1:0] rx_sync;
        logic [CMC_CNT_W-1:0] en_cnt;
        logic en_done;
        logic armed;
        logic woken;
        logic drive;
        logic drv_en;
        logic rxo;
        logic wake;
        logic [2:0] chip_prev;
    } cmc_st_s;
    cmc_st_s st_ff;
    cmc_st_s nxt_st;
    logic wake_hit;
    localparam logic [CMC_CNT_W-1:0] EN_LAST = CMC_CNT_W'(EN_CYC - 1);

    function automatic logic mode_allowed(input logic [1:0] m, input logic [2:0] cm);
        unique case (m)
            CMC_MODE_OFF: mode_allowed = 1'b1;
            CMC_MODE_NORMAL: mode_allowed = (cm == CMC_CHIP_NORMAL);
            CMC_MODE_RXONLY: mode_allowed = (cm == CMC_CHIP_NORMAL) || (cm == CMC_CHIP_STOP);
            default: mode_allowed = 1'b1;
        endcase
    endfunction : mode_allowed

    // detector sees only the synchronised bus; disabled outside wake capable mode
    cmc_wake_det #(
        .WAKE1_CYC(WAKE1_CYC),
        .WAKE2_CYC(WAKE2_CYC)
    ) u_wake (
        .clk(clk),
        .resetn(resetn),
        .enable(st_ff.mode == CMC_MODE_WAKE && st_ff.armed && !st_ff.woken),
        .bus_dom(st_ff.rx_sync[1]),
        .wake_ff(wake_hit)
    );

    always_comb begin
        nxt_st = st_ff;
        nxt_st.tx_sync = {st_ff.tx_sync[0], tx_data_in};
        nxt_st.rx_sync = {st_ff.rx_sync[0], bus_rx_dom};
        nxt_st.chip_prev = chip_mode;
        nxt_st.wake = 1'b0;
        if (mode_cmd.valid && mode_allowed(mode_cmd.mode, chip_mode)) begin
            nxt_st.mode = mode_cmd.mode;
            nxt_st.woken = 1'b0;
            nxt_st.armed = 1'b1;
            if (mode_cmd.mode == CMC_MODE_NORMAL) begin
                nxt_st.en_cnt = '0;
                nxt_st.en_done = 1'b0;
            end
        end else if (st_ff.mode == CMC_MODE_NORMAL && chip_mode != CMC_CHIP_NORMAL) begin
            nxt_st.mode = CMC_MODE_OFF;
        end
        // automatic rearm when the chip drops into a low-power or fail-safe mode
        if (chip_mode != st_ff.chip_prev && (chip_mode == CMC_CHIP_STOP ||
            chip_mode == CMC_CHIP_SLEEP || chip_mode == CMC_CHIP_FAILSAFE)) begin
            nxt_st.woken = 1'b0;
        end
        // fail-safe forces wake capable and must also re-open the detector gate
        if (chip_mode == CMC_CHIP_FAILSAFE) begin
            nxt_st.mode = CMC_MODE_WAKE;
            nxt_st.armed = 1'b1;
        end
        if (wake_hit && st_ff.mode == CMC_MODE_WAKE) begin
            nxt_st.woken = 1'b1;
            nxt_st.wake = 1'b1;
        end
        if (st_ff.mode == CMC_MODE_NORMAL && !st_ff.en_done) begin
            if (st_ff.en_cnt == EN_LAST) begin
                nxt_st.en_done = 1'b1;
            end else begin
                nxt_st.en_cnt = st_ff.en_cnt + 1'b1;
            end
        end
        // a low input held across the end of enabling stays blocked until it goes high
        if (st_ff.mode == CMC_MODE_NORMAL && st_ff.en_done && st_ff.tx_sync[1]) begin
            nxt_st.armed = 1'b1;
        end else if (st_ff.mode == CMC_MODE_NORMAL && !st_ff.en_done) begin
            nxt_st.armed = 1'b0;
        end
        nxt_st.drv_en = (nxt_st.mode == CMC_MODE_NORMAL);
        nxt_st.drive = (st_ff.mode == CMC_MODE_NORMAL) && (nxt_st.mode == CMC_MODE_NORMAL) &&
            st_ff.en_done && st_ff.armed && !st_ff.tx_sync[1];
        unique case (st_ff.mode)
            CMC_MODE_NORMAL, CMC_MODE_RXONLY: nxt_st.rxo = !st_ff.rx_sync[1];
            CMC_MODE_WAKE: nxt_st.rxo = !(st_ff.woken || wake_hit);
            default: nxt_st.rxo = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '{mode: CMC_MODE_RESET, tx_sync: 2'h3, rx_sync: 2'h0,
                       en_cnt: '0, en_done: 1'b0, armed: 1'b0, woken: 1'b0, drive: 1'b0,
                       drv_en: 1'b0, rxo: 1'b1, wake: 1'b0, chip_prev: CMC_CHIP_NORMAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign mode_out = st_ff.mode;
    assign bus_drive_dom = st_ff.drive;
    assign drv_enable = st_ff.drv_en;
    assign rx_data_out = st_ff.rxo;
    assign wake_event = st_ff.wake;

    a_no_early_dom: assert property (@(posedge clk) disable iff (!resetn)
        $rose(st_ff.mode == CMC_MODE_NORMAL) |-> !bus_drive_dom [*8])
        else $error("dominant driven inside enabling time");
    a_off_no_drive: assert property (@(posedge clk) disable iff (!resetn)
        (st_ff.mode != CMC_MODE_NORMAL) |=> !bus_drive_dom)
        else $error("driver active outside normal mode");
    a_off_no_wake: assert property (@(posedge clk) disable iff (!resetn)
        (st_ff.mode == CMC_MODE_OFF) |=> !wake_event)
        else $error("wake raised in off mode");
    a_normal_gate: assert property (@(posedge clk) disable iff (!resetn)
        ($past(st_ff.mode) != CMC_MODE_NORMAL && st_ff.mode == CMC_MODE_NORMAL)
        |-> $past(mode_cmd.valid && chip_mode == CMC_CHIP_NORMAL))
        else $error("normal mode entered without command");
    a_rxonly_drv: assert property (@(posedge clk) disable iff (!resetn)
        (st_ff.mode == CMC_MODE_RXONLY) |=> !drv_enable)
        else $error("driver enabled in receive only");
    a_woken_rx_low: assert property (@(posedge clk) disable iff (!resetn)
        (st_ff.woken && st_ff.mode == CMC_MODE_WAKE) |=> !rx_data_out)
        else $error("receive output not low after wake");
    a_wake_code: assert property (@(posedge clk) disable iff (!resetn)
        wake_event |-> mode_out == 2'h1)
        else $error("wake with wrong mode code");
    a_rx_follow: assert property (@(posedge clk) disable iff (!resetn)
        (st_ff.mode == CMC_MODE_RXONLY && $past(st_ff.mode) == CMC_MODE_RXONLY)
        |=> rx_data_out == !$past(st_ff.rx_sync[1]))
        else $error("receive output does not follow bus");
    a_tx_pass: assert property (@(posedge clk) disable iff (!resetn)
        (st_ff.mode == CMC_MODE_NORMAL && st_ff.en_done && st_ff.armed &&
         st_ff.tx_sync[1] && !(mode_cmd.valid)) |=> !bus_drive_dom)
        else $error("recessive input drove dominant");
endmodule : cmc_top
`default_nettype wire

// ---- verilog/cmc_wake_det.sv ----
// Purpose: bus wake pattern detector: dominant, recessive, dominant phases
// Assumes: bus_dom already synchronised to clk
// Notes: dominant phases in window [wake1, wake2], recessive phase longer than wake1; only runs while enabled
`timescale 1ns/1ps
`default_nettype none
module cmc_wake_det #(
    parameter int WAKE1_CYC = cmc_pkg::CMC_WAKE1_CYC,
    parameter int WAKE2_CYC = cmc_pkg::CMC_WAKE2_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic bus_dom,
    output logic wake_ff
);
    import cmc_pkg::*;
    typedef struct packed {
        cmc_wst_e st;
        logic [21:0] cnt;
        logic wake;
    } cmc_wd_s;
    cmc_wd_s st_ff;
    cmc_wd_s nxt_st;
    localparam logic [21:0] W1 = 22'(WAKE1_CYC);
    localparam logic [21:0] W2 = 22'(WAKE2_CYC);
    always_comb begin
        nxt_st = st_ff;
        nxt_st.wake = 1'b0;
        if (st_ff.cnt != 22'h3FFFFF) begin
            nxt_st.cnt = st_ff.cnt + 22'h1;
        end
        if (!enable) begin
            nxt_st.st = CMC_W_IDLE;
            nxt_st.cnt = 22'h0;
        end else begin
            unique case (st_ff.st)
                CMC_W_IDLE: begin
                    if (bus_dom) begin
                        nxt_st.st = CMC_W_DOM1;
                        nxt_st.cnt = 22'h0;
                    end
                end
                CMC_W_DOM1, CMC_W_DOM2: begin
                    if (st_ff.cnt >= W2) begin
                        nxt_st.st = CMC_W_IDLE;
                    end else if (!bus_dom) begin
                        nxt_st.cnt = 22'h0;
                        if (st_ff.cnt + 22'h1 < W1) begin
                            nxt_st.st = CMC_W_IDLE;
                        end else if (st_ff.st == CMC_W_DOM2) begin
                            nxt_st.st = CMC_W_IDLE;
                            nxt_st.wake = 1'b1;
                        end else begin
                            nxt_st.st = CMC_W_REC;
                        end
                    end
                end
                CMC_W_REC: begin
                    if (st_ff.cnt >= W2) begin
                        nxt_st.st = CMC_W_IDLE;
                    end else if (bus_dom) begin
                        nxt_st.cnt = 22'h0;
                        nxt_st.st = (st_ff.cnt + 22'h1 > W1) ? CMC_W_DOM2 : CMC_W_DOM1;
                    end
                end
                default: nxt_st.st = CMC_W_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_ff <= '{st: CMC_W_IDLE, cnt: 22'h0, wake: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign wake_ff = st_ff.wake;
endmodule : cmc_wake_det
`default_nettype wire
